// File: rtl/psm_ctrl.sv
// psm_ctrl.sv: doze throttling, sleep and idle entry, wake sequencing, status flags
// assumes the core sequencer pulses its strobes once per instruction cycle event,
// and that readiness and reset-source inputs arrive from other clock domains
`timescale 1ns/1ns
`default_nettype none
`include "psm_defs.svh"

module psm_ctrl
    import psm_pkg::*;
#(
    parameter int NUM_SRC   = `PSM_NUM_SRC,
    parameter int CLKSW_SRC = `PSM_CLKSW_SRC,
    parameter int OST_COUNT = `PSM_OST_PERIODS
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    // control bits written by software
    input  wire logic               sw_write,
    input  wire logic               sw_slow_run_enable,
    input  wire logic               fast_on_interrupt,
    input  wire logic               slow_on_exit,
    input  wire logic               idle_select,
    input  wire logic [2:0]         slow_run_ratio,
    input  wire logic               global_interrupt_enable,
    // interrupt sources
    input  wire logic [NUM_SRC-1:0] src_flag,
    input  wire logic [NUM_SRC-1:0] source_interrupt_enable,
    // core sequencer strobes
    input  wire logic               q_cycle_end,
    input  wire logic               sleep_exec,
    input  wire logic               isr_enter,
    input  wire logic               isr_return,
    input  wire logic               multicycle_busy,
    input  wire logic               prefetch_clears_ie,
    input  wire logic               watchdog_wake,
    // reset sources and readiness (asynchronous)
    input  wire logic               external_reset_pin,
    input  wire logic               brownout_reset,
    input  wire logic               low_power_brownout_reset,
    input  wire logic               power_on_event,
    input  wire logic               watchdog_reset,
    input  wire logic               program_memory_ready,
    input  wire logic               sys_clock_ready,
    input  wire logic               brownout_ready,
    input  wire logic               brownout_enabled,
    input  wire logic               crystal_mode,
    input  wire logic               osc_tick,
    // outputs
    output logic                    slow_run_enable,
    output logic                    cpu_cycle_enable,
    output logic                    periph_clock_enable,
    output logic                    cpu_clock_enable,
    output logic                    port_hold,
    output logic                    vector_fetch,
    output logic                    prefetch_next,
    output logic                    device_reset_req,
    output logic                    watchdog_clear,
    output logic                    power_down_flag_n,
    output logic                    timeout_flag_n,
    output logic                    sleep_nop,
    output psm_state_t              power_state
);

    // --------------------------------------------------------
    // input synchronisers: three stages, change when 2 and 3 agree
    // --------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] filt_q;

    assign raw_in = {external_reset_pin, brownout_reset, low_power_brownout_reset,
                     power_on_event, program_memory_ready, sys_clock_ready,
                     brownout_ready, brownout_enabled, crystal_mode, osc_tick};

    // chain of three flops per input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // filtered level follows only when the last two stages agree
    genvar si;
    generate
        for (si = 0; si < NSYNC; si++) begin : g_filt
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    filt_q[si] <= 1'b0;
                end else if (s2_q[si] == s3_q[si]) begin
                    filt_q[si] <= s3_q[si];
                end
            end
        end
    endgenerate

    logic xrst_s, bo_s, lpbo_s, por_s, mem_rdy_s, clk_rdy_s, bo_rdy_s;
    logic bo_en_s, xtal_s, osc_s, osc_prev_q, osc_edge;
    assign {xrst_s, bo_s, lpbo_s, por_s, mem_rdy_s, clk_rdy_s,
            bo_rdy_s, bo_en_s, xtal_s, osc_s} = filt_q;

    // oscillator edge for the start-up count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
        end
    end
    assign osc_edge = osc_s & ~osc_prev_q;

    // --------------------------------------------------------
    // wake request from enabled sources
    // --------------------------------------------------------
    logic wake_any;

    psm_wake_detect #(
        .NUM_SRC   (NUM_SRC),
        .CLKSW_SRC (CLKSW_SRC)
    ) u_wake (
        .src_flag   (src_flag),
        .src_enable (source_interrupt_enable),
        .wake_any   (wake_any)
    );

    // --------------------------------------------------------
    // state machine
    // --------------------------------------------------------
    psm_state_t state_q;
    psm_state_t state_d;
    logic [`PSM_OST_CNT_W-1:0] ost_q;
    logic any_reset;
    logic sleep_go;
    logic ready_all;
    logic wake_done;

    // watchdog resets in every state but idle; in idle it wakes instead
    assign any_reset = xrst_s | bo_s | lpbo_s | por_s
                       | (watchdog_reset & (state_q != PSM_IDLE));
    assign sleep_go  = sleep_exec & ~(wake_any & ~global_interrupt_enable);
    assign ready_all = mem_rdy_s & clk_rdy_s & (bo_rdy_s | ~bo_en_s);
    assign wake_done = (state_q == PSM_OST) && (ost_q == `PSM_OST_CNT_ZERO);

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            PSM_RUN: begin
                if (sleep_go) begin
                    state_d = idle_select ? PSM_IDLE : PSM_SLEEP;
                end
            end
            PSM_SLEEP: begin
                // a late interrupt leaves at once, sleep already completed
                if (wake_any || watchdog_wake) begin
                    state_d = PSM_WAKE;
                end
            end
            PSM_IDLE: begin
                if (wake_any || watchdog_wake || watchdog_reset) begin
                    state_d = PSM_RUN;
                end
            end
            PSM_WAKE: begin
                if (ready_all) begin
                    state_d = PSM_OST;
                end
            end
            PSM_OST: begin
                if (wake_done) begin
                    state_d = PSM_RUN;
                end
            end
            default: state_d = PSM_RUN;
        endcase
    end

    // state register; resets override all sleeps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PSM_RUN;
        end else if (any_reset) begin
            state_q <= PSM_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // start-up wait, zero length outside crystal modes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ost_q <= `PSM_OST_CNT_ZERO;
        end else if (state_q == PSM_WAKE) begin
            ost_q <= xtal_s ? `PSM_OST_CNT_W'(OST_COUNT) : `PSM_OST_CNT_ZERO;
        end else if (state_q == PSM_OST && ost_q != `PSM_OST_CNT_ZERO && osc_edge) begin
            ost_q <= ost_q - `PSM_OST_CNT_ONE;
        end
    end

    // --------------------------------------------------------
    // slow-run enable: software write, isr entry and return
    // --------------------------------------------------------
    logic slow_q;
    logic slow_prev_q;
    logic vec_pend_q;

    // hardware set wins over software clear on a collision
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_q <= 1'b0;
        end else if (isr_return && slow_on_exit) begin
            slow_q <= 1'b1;
        end else if (fast_on_interrupt
                     && (isr_enter || (vec_pend_q && prefetch_clears_ie))) begin
            slow_q <= 1'b0;
        end else if (sw_write) begin
            slow_q <= sw_slow_run_enable;
        end
    end
    assign slow_run_enable = slow_q;

    // interrupt taken while running: vector fetch waits for multicycle end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_pend_q <= 1'b0;
        end else if (isr_enter || prefetch_clears_ie) begin
            vec_pend_q <= 1'b0;
        end else if (state_q == PSM_RUN && wake_any && global_interrupt_enable) begin
            vec_pend_q <= 1'b1;
        end
    end
    // prefetch clearing the global enable suppresses the vector
    assign vector_fetch = vec_pend_q & ~multicycle_busy & ~prefetch_clears_ie;

    // --------------------------------------------------------
    // doze throttle counter
    // --------------------------------------------------------
    logic [`PSM_DOZE_CNT_W-1:0] doze_cnt_q;
    logic [`PSM_DOZE_CNT_W-1:0] doze_last;

    // ratio code k gives 2^(k+1) cycles; last count is N-1
    assign doze_last = (`PSM_RATIO_BASE << ({1'b0, slow_run_ratio} + 4'd1))
                       - `PSM_RATIO_BASE;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_prev_q <= 1'b0;
        end else begin
            slow_prev_q <= slow_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doze_cnt_q <= `PSM_DOZE_CNT_ZERO;
        end else if (slow_q != slow_prev_q) begin
            doze_cnt_q <= `PSM_DOZE_CNT_W'(slow_q & q_cycle_end);
        end else if (slow_q && q_cycle_end) begin
            // e.g. code 001 counts 0..3: one run, three idle
            doze_cnt_q <= (doze_cnt_q >= doze_last) ? `PSM_DOZE_CNT_ZERO
                                                    : doze_cnt_q + 8'h01;
        end
    end

    // --------------------------------------------------------
    // clock and cycle gating
    // --------------------------------------------------------
    logic running;
    assign running = (state_q == PSM_RUN);
    // every cycle runs while slow-run is clear, else only on doze count zero; a pending vector does not bypass it
    assign cpu_cycle_enable = running & (~slow_q
                              | (doze_cnt_q == `PSM_DOZE_CNT_ZERO));
    assign cpu_clock_enable = running;
    // only full sleep stops system-clocked peripherals; doze never does
    assign periph_clock_enable = (state_q != PSM_SLEEP);
    // other oscillators are outside this block and never gated here
    assign port_hold = (state_q == PSM_SLEEP);

    // --------------------------------------------------------
    // registered strobes and status flags
    // --------------------------------------------------------
    logic entering_sleep;
    logic leaving_sleep;
    assign entering_sleep = running && sleep_go && !idle_select && !any_reset;
    assign leaving_sleep  = wake_done && !any_reset;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_clear   <= 1'b0;
            prefetch_next    <= 1'b0;
            sleep_nop        <= 1'b0;
            device_reset_req <= 1'b0;
        end else begin
            watchdog_clear   <= entering_sleep | leaving_sleep;
            prefetch_next    <= running & sleep_go;
            sleep_nop        <= running & sleep_exec & ~sleep_go;
            device_reset_req <= any_reset;
        end
    end

    // power-down and timeout flags, held on a nop sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down_flag_n <= `PSM_FLAG_RST;
            timeout_flag_n    <= `PSM_FLAG_RST;
        end else if (entering_sleep) begin
            power_down_flag_n <= 1'b0;
            timeout_flag_n    <= 1'b1;
        end
    end

    assign power_state = state_q;

endmodule

`default_nettype wire

// File: common/psm_defs.svh
// psm_defs.svh: timing counts, codes and reset values of the power-saving control
// assumes inclusion by bare name from the package and the design files
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// ---------------------------------------------------------------
// instruction cycle and ratio
// ---------------------------------------------------------------
`define PSM_QCLK_PER_CYC   2'd3
`define PSM_RATIO_W        3
`define PSM_RATIO_BASE     8'h01
`define PSM_DOZE_CNT_W     8
`define PSM_DOZE_CNT_ZERO  8'h00

// ---------------------------------------------------------------
// oscillator start-up wait, in oscillator periods
// ---------------------------------------------------------------
`define PSM_OST_PERIODS    1024
`define PSM_OST_CNT_W      11
`define PSM_OST_CNT_ZERO   11'h000
`define PSM_OST_CNT_ONE    11'h001

// ---------------------------------------------------------------
// interrupt sources and reset values
// ---------------------------------------------------------------
`define PSM_NUM_SRC        48
`define PSM_CLKSW_SRC      12
`define PSM_FLAG_RST       1'b1

`endif

// File: common/psm_pkg.sv
// psm_pkg.sv: types shared by the power-saving control
// assumes psm_defs.svh is on the include path
`include "psm_defs.svh"

package psm_pkg;

    // power state of the core
    typedef enum logic [2:0] {
        PSM_RUN   = 3'b000,
        PSM_SLEEP = 3'b001,
        PSM_IDLE  = 3'b010,
        PSM_WAKE  = 3'b011,
        PSM_OST   = 3'b100
    } psm_state_t;

endpackage

// File: rtl/psm_wake_detect.sv
// psm_wake_detect.sv: combines per-source flags and enables into one wake request
// assumes flags and enables come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "psm_defs.svh"

module psm_wake_detect
    import psm_pkg::*;
#(
    parameter int NUM_SRC   = `PSM_NUM_SRC,
    parameter int CLKSW_SRC = `PSM_CLKSW_SRC
) (
    input  wire logic [NUM_SRC-1:0] src_flag,
    input  wire logic [NUM_SRC-1:0] src_enable,
    output logic                    wake_any
);

    logic [NUM_SRC-1:0] hit;

    // --------------------------------------------------------
    // per-source gating, clock-switch source never wakes
    // --------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
            if (gi == CLKSW_SRC) begin : g_clksw
                assign hit[gi] = 1'b0;
            end else begin : g_norm
                assign hit[gi] = src_flag[gi] & src_enable[gi];
            end
        end
    endgenerate

    // global enable deliberately absent here
    assign wake_any = |hit;

endmodule

`default_nettype wire

// File: sim/psm_checker.sv
// psm_checker.sv: port-level assertions for the power-saving control
// assumes binding onto psm_ctrl, one clock domain, reset low
`timescale 1ns/1ns
`default_nettype none

module psm_checker
    import psm_pkg::*;
#(
    parameter int NUM_SRC   = 48,
    parameter int CLKSW_SRC = 12
) (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               idle_select,
    input wire logic               global_interrupt_enable,
    input wire logic [NUM_SRC-1:0] src_flag,
    input wire logic [NUM_SRC-1:0] source_interrupt_enable,
    input wire logic               sleep_exec,
    input wire logic               isr_enter,
    input wire logic               isr_return,
    input wire logic               fast_on_interrupt,
    input wire logic               slow_on_exit,
    input wire logic               multicycle_busy,
    input wire logic               watchdog_wake,
    input wire logic               slow_run_enable,
    input wire logic               periph_clock_enable,
    input wire logic               cpu_clock_enable,
    input wire logic               port_hold,
    input wire logic               vector_fetch,
    input wire logic               prefetch_next,
    input wire logic               watchdog_clear,
    input wire logic               power_down_flag_n,
    input wire logic               timeout_flag_n,
    input wire logic               sleep_nop,
    input wire psm_state_t         power_state
);
    // ---------------------------------------------------------------
    // helper logic
    // ---------------------------------------------------------------
    logic [NUM_SRC-1:0] en_m;
    logic               wake_any;
    logic               go_sleep;

    // clock-switch source masked out, it can never wake
    always_comb begin
        en_m = source_interrupt_enable;
        en_m[CLKSW_SRC] = 1'h0;
    end
    assign wake_any = |(src_flag & en_m);
    assign go_sleep = sleep_exec && power_state == PSM_RUN
                      && !(wake_any && !global_interrupt_enable);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_sleep_entry: assert property (go_sleep && !idle_select |=> power_state == PSM_SLEEP
        && !power_down_flag_n && timeout_flag_n) else $error("sleep entry wrong");
    a_entry_strobes: assert property (go_sleep && !idle_select
        |=> watchdog_clear && prefetch_next) else $error("entry strobes missing");
    a_nop_refuse: assert property (sleep_exec && power_state == PSM_RUN && wake_any
        && !global_interrupt_enable |=> sleep_nop && power_state == PSM_RUN
        && $stable(power_down_flag_n) && $stable(timeout_flag_n) && !watchdog_clear)
        else $error("refused sleep changed state");
    a_idle_entry: assert property (go_sleep && idle_select |=> power_state == PSM_IDLE)
        else $error("idle not entered");
    a_sleep_gating: assert property (power_state == PSM_SLEEP
        |-> port_hold && !periph_clock_enable && !cpu_clock_enable) else $error("sleep gating");
    a_idle_periph: assert property (power_state == PSM_IDLE
        |-> periph_clock_enable && !cpu_clock_enable) else $error("idle gating");
    a_run_periph: assert property (power_state == PSM_RUN
        |-> periph_clock_enable && !port_hold) else $error("run gating");
    a_flag_wakes: assert property (power_state == PSM_SLEEP && wake_any
        |=> power_state != PSM_SLEEP) else $error("no wake on flag");
    a_clksw_quiet: assert property (power_state == PSM_SLEEP && !wake_any && !watchdog_wake
        |=> power_state != PSM_WAKE) else $error("spurious wake");
    a_fast_clear: assert property (isr_enter && fast_on_interrupt && !isr_return
        |=> !slow_run_enable) else $error("slow run not cleared");
    a_slow_exit: assert property (isr_return && slow_on_exit |=> slow_run_enable)
        else $error("slow run not set");
    a_vector_busy: assert property (vector_fetch |-> !multicycle_busy)
        else $error("vector during multicycle");
    a_wake_clear: assert property (power_state == PSM_OST ##1 power_state == PSM_RUN
        |-> ##[0:1] watchdog_clear) else $error("no clear on wake");

    // main scenarios reached
    c_sleep: cover property (go_sleep && !idle_select);
    c_nop: cover property (sleep_nop);
    c_idle: cover property (power_state == PSM_IDLE);
    c_ost: cover property (power_state == PSM_OST ##1 power_state == PSM_RUN);
endmodule

bind psm_ctrl psm_checker #(.NUM_SRC(NUM_SRC), .CLKSW_SRC(CLKSW_SRC)) u_chk (.*);

`default_nettype wire

// File: sim/psm_core_model.sv
// psm_core_model.sv: core sequencer cycle strobe and a free oscillator tick
// assumes the same clock and reset as the power-saving control
`timescale 1ns/1ns
`default_nettype none

module psm_core_model (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      q_cycle_end,
    output logic      osc_tick
);
    logic [1:0] q_q;
    logic [1:0] o_q;

    // four phase clocks per instruction cycle, strobe on the last
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_q <= 2'h0;
            q_cycle_end <= 1'h0;
        end else begin
            q_q <= q_q + 2'h1;
            q_cycle_end <= (q_q == 2'h2);
        end
    end

    // slow oscillator, not a multiple of the cycle so phases drift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o_q <= 2'h0;
            osc_tick <= 1'h0;
        end else begin
            o_q <= (o_q == 2'h2) ? 2'h0 : o_q + 2'h1;
            osc_tick <= (o_q == 2'h2) ? !osc_tick : osc_tick;
        end
    end
endmodule

`default_nettype wire

// File: sim/testbench.sv
// testbench.sv: self-checking bench for the power-saving control
// assumes psm_ctrl, psm_core_model and the bound checker are compiled
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module testbench;
    import psm_pkg::*;
    localparam int OST = 4;
    logic clk, rst_n, sw_write, sw_slow_run_enable, fast_on_interrupt, slow_on_exit;
    logic idle_select, global_interrupt_enable, sleep_exec, isr_enter, isr_return;
    logic multicycle_busy, prefetch_clears_ie, watchdog_wake, external_reset_pin;
    logic brownout_reset, low_power_brownout_reset, power_on_event, watchdog_reset;
    logic program_memory_ready, sys_clock_ready, brownout_ready, brownout_enabled, crystal_mode;
    logic [2:0]  slow_run_ratio;
    logic [47:0] src_flag, source_interrupt_enable;
    logic q_cycle_end, osc_tick, slow_run_enable, cpu_cycle_enable, periph_clock_enable;
    logic cpu_clock_enable, port_hold, vector_fetch, prefetch_next, device_reset_req;
    logic watchdog_clear, power_down_flag_n, timeout_flag_n, sleep_nop;
    psm_state_t power_state;
    int failures = 0;
    int total_checks = 0;
    int idx;
    logic [9:0] ens;
    logic wc;

    psm_ctrl #(.OST_COUNT(OST)) dut (.*);
    psm_core_model u_core (.clk(clk), .rst_n(rst_n), .q_cycle_end(q_cycle_end),
        .osc_tick(osc_tick));

    // ---------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ---------------------------------------------------------------
    always #20 clk = ~clk;

    // bound far above the doze sweep, some 4k cycles
    initial begin
        #(40 * 20000);
        failures++;
        stop_test();
    end

    task automatic stop_test;
        if (failures == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wait_st(input psm_state_t s, input int lim);
        for (int i = 0; i < lim && power_state !== s; i++) @(negedge clk);
        `CHK("power_state", s, power_state)
    endtask

    task automatic do_sleep;
        @(posedge clk);
        sleep_exec <= 1'h1;
        @(posedge clk);
        sleep_exec <= 1'h0;
        @(negedge clk);
    endtask

    task automatic sw_set(input logic v);
        @(posedge clk);
        sw_slow_run_enable <= v;
        sw_write <= 1'h1;
        @(posedge clk);
        sw_write <= 1'h0;
    endtask

    task automatic isr_pulse(input bit ent);
        @(posedge clk);
        if (ent) isr_enter <= 1'h1;
        else isr_return <= 1'h1;
        @(posedge clk);
        isr_enter <= 1'h0;
        isr_return <= 1'h0;
        @(negedge clk);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'h0;
        rst_n = 1'h0;
        {sw_write, sw_slow_run_enable, fast_on_interrupt, slow_on_exit, idle_select} = '0;
        {global_interrupt_enable, sleep_exec, isr_enter, isr_return, multicycle_busy} = '0;
        {prefetch_clears_ie, watchdog_wake, external_reset_pin, brownout_reset} = '0;
        {low_power_brownout_reset, power_on_event, watchdog_reset, crystal_mode} = '0;
        {program_memory_ready, sys_clock_ready, brownout_ready, brownout_enabled} = 4'hF;
        slow_run_ratio = 3'h0;
        src_flag = 48'h0;
        source_interrupt_enable = 48'h0;
        idx = $urandom(95626);
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        `CHK("pd_rst", 1'h1, power_down_flag_n)
        `CHK("to_rst", 1'h1, timeout_flag_n)
        // each ratio code over two doze periods
        for (int c = 0; c < 8; c++) begin
            slow_run_ratio <= c[2:0];
            multicycle_busy <= 1'($urandom_range(0, 1));
            sw_set(1'h1);
            ens = 10'h0;
            for (int k = 0; k < (4 << c); k++) begin
                @(negedge clk);
                while (!q_cycle_end) @(negedge clk);
                if (k == 0) `CHK("doze_first", 1'h1, cpu_cycle_enable)
                ens = ens + 10'(cpu_cycle_enable);
            end
            `CHK("doze_cycles", 10'h2, ens)
            sw_set(1'h0);
        end
        multicycle_busy <= 1'h0;
        fast_on_interrupt <= 1'h0;
        sw_set(1'h1);
        isr_pulse(1);
        `CHK("slow_keep", 1'h1, slow_run_enable)
        fast_on_interrupt <= 1'h1;
        isr_pulse(1);
        `CHK("slow_fast", 1'h0, slow_run_enable)
        slow_on_exit <= 1'h1;
        isr_pulse(0);
        `CHK("slow_exit", 1'h1, slow_run_enable)
        {fast_on_interrupt, slow_on_exit} <= 2'h0;
        sw_set(1'h0);
        idx = $urandom_range(0, 46);
        if (idx >= 12) idx++;
        // flag up, global enable set: sleep runs, then wakes
        src_flag[idx] <= 1'h1;
        source_interrupt_enable[idx] <= 1'h1;
        global_interrupt_enable <= 1'h1;
        do_sleep();
        `CHK("pd_late", 1'h0, power_down_flag_n)
        `CHK("wdc_late", 1'h1, watchdog_clear)
        wait_st(PSM_RUN, 16);
        // clock-switch flag alone keeps sleep; wake then waits for memory ready and start-up count
        src_flag <= 48'h1000;
        source_interrupt_enable <= 48'h1000;
        global_interrupt_enable <= 1'($urandom_range(0, 1));
        crystal_mode <= 1'h1;
        program_memory_ready <= 1'h0;
        do_sleep();
        `CHK("prefetch", 1'h1, prefetch_next)
        `CHK("wdc_entry", 1'h1, watchdog_clear)
        `CHK("port_hold", 1'h1, port_hold)
        `CHK("periph_off", 1'h0, periph_clock_enable)
        `CHK("to_entry", 1'h1, timeout_flag_n)
        repeat (10) @(negedge clk);
        `CHK("clksw_sleep", PSM_SLEEP, power_state)
        src_flag[idx] <= 1'h1;
        source_interrupt_enable[idx] <= 1'h1;
        wait_st(PSM_WAKE, 5);
        repeat (10) @(negedge clk);
        `CHK("mem_wait", PSM_WAKE, power_state)
        program_memory_ready <= 1'h1;
        wait_st(PSM_OST, 10);
        repeat (8) @(negedge clk);
        `CHK("ost_wait", PSM_OST, power_state)
        wc = 1'h0;
        for (int i = 0; i < 60 && power_state !== PSM_RUN; i++) begin
            @(negedge clk);
            wc = wc | watchdog_clear;
        end
        @(negedge clk);
        wc = wc | watchdog_clear;
        `CHK("wake_wdc", 1'h1, wc)
        global_interrupt_enable <= 1'h0;
        do_sleep();
        `CHK("nop", 1'h1, sleep_nop)
        `CHK("nop_pd", 1'h0, power_down_flag_n)
        `CHK("nop_state", PSM_RUN, power_state)
        {src_flag, source_interrupt_enable} <= 96'h0;
        {crystal_mode, idle_select} <= 2'h1;
        do_sleep();
        `CHK("idle", PSM_IDLE, power_state)
        `CHK("idle_periph", 1'h1, periph_clock_enable)
        src_flag[idx] <= 1'h1;
        source_interrupt_enable[idx] <= 1'h1;
        wait_st(PSM_RUN, 16);
        {src_flag, source_interrupt_enable} <= 96'h0;
        do_sleep();
        watchdog_reset <= 1'h1;
        wait_st(PSM_RUN, 4);
        `CHK("wdt_idle", 1'h0, device_reset_req)
        {watchdog_reset, idle_select} <= 2'h0;
        // each non-watchdog reset source ends sleep with a device reset
        for (int s = 0; s < 4; s++) begin
            do_sleep();
            {power_on_event, low_power_brownout_reset, brownout_reset,
                external_reset_pin} <= 4'h1 << s;
            for (int i = 0; i < 12 && device_reset_req !== 1'h1; i++) @(negedge clk);
            `CHK("rst_req", 1'h1, device_reset_req)
            `CHK("rst_state", PSM_RUN, power_state)
            {power_on_event, low_power_brownout_reset, brownout_reset,
                external_reset_pin} <= 4'h0;
            repeat (6) @(posedge clk);
            rst_n <= 1'h0;
            repeat (2) @(posedge clk);
            rst_n <= 1'h1;
        end
        stop_test();
    end
endmodule

`default_nettype wire
